// ===== common/a4sf_defs.svh
// Constants for the ARINC 429 SPI front end: timing, opcodes, pin indices.
// Contract
// - Clear pulse empties all FIFOs and flags.
// - SPI data moves only while select low.
// - Four-wire SPI works up to 10MHz.
// - Transmit FIFO holds 32 words of 32.
// - Each receiver FIFO holds 32 words of 32.
// - Receivers store only words with enabled labels; a mailbox label match is stored even when its label is not enabled.
// - Three mailboxes per receiver, one data register each.
// - Six mailbox pins high while unread.
// - Transmit-empty pin high when FIFO empty.
// - Transmit-full pin high at 32 words.
// - Flag pin follows assigned receiver condition.
// - Per-receiver interrupt with programmable condition.
// - FIFO and mailbox state readable over SPI.
// - Transmit and receive rates chosen independently.
// - Line bit timing derives from timing clock.
`ifndef A4SF_DEFS_SVH
`define A4SF_DEFS_SVH
`define A4SF_WORD_W 32
`define A4SF_FIFO_DEPTH 32
`define A4SF_CLK_HZ 50000000
`define A4SF_SPI_MAX_HZ 10000000
`define A4SF_SPI_CYC (`A4SF_CLK_HZ / `A4SF_SPI_MAX_HZ)
`define A4SF_ACLK_HZ 1000000
`define A4SF_BPS_HI 100000
`define A4SF_BPS_LO 12500
`define A4SF_HALF_HI (`A4SF_ACLK_HZ / (2 * `A4SF_BPS_HI))
`define A4SF_HALF_LO (`A4SF_ACLK_HZ / (2 * `A4SF_BPS_LO))
`define A4SF_TX_GAP_HALF 6'h08
`define A4SF_RX_GAP_HALF 4'h4
`define A4SF_SYNC_RST 9'h040
`define A4SF_I_CLR 8
`define A4SF_I_ACLK 7
`define A4SF_I_CS 6
`define A4SF_I_SCLK 5
`define A4SF_I_MOSI 4
`define A4SF_CMD_CFG 8'h01
`define A4SF_CMD_ASSIGN 8'h02
`define A4SF_CMD_TXW 8'h03
`define A4SF_CMD_LBL_A 8'h04
`define A4SF_CMD_LBL_B 8'h05
`define A4SF_CMD_MBL_A 8'h06
`define A4SF_CMD_MBL_B 8'h07
`define A4SF_CMD_RXR_A 8'h08
`define A4SF_CMD_RXR_B 8'h09
`define A4SF_CMD_STAT 8'h0A
`define A4SF_CMD_MBR_HI 4'h1
`endif

// ===== common/a4sf_pkg.sv
// Types shared by the ARINC 429 SPI front end.
package a4sf_pkg;
   // Digital line pair: hi drives the positive half, lo the negative.
   typedef struct packed {
      logic hi;
      logic lo;
   } a4sf_line_t;
   // Conditions selectable for flag and interrupt pins.
   typedef enum logic [1:0] {
      A4SF_C_NONEMPTY,
      A4SF_C_HALF,
      A4SF_C_FULL,
      A4SF_C_MBOX
   } a4sf_cond_t;
   // Transmit serializer states.
   typedef enum logic [1:0] {
      A4SF_TX_IDLE,
      A4SF_TX_BIT,
      A4SF_TX_GAP
   } a4sf_tx_st_t;
endpackage

// ===== logic/a4sf_top.sv
// ARINC 429 SPI front end: FIFO module and top-level core.
`timescale 1ns/1ps
`include "a4sf_defs.svh"

module a4sf_fifo #(
   parameter int W = `A4SF_WORD_W,
   parameter int D = `A4SF_FIFO_DEPTH
) (
   input wire logic clk, // System clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic clr, // Synchronous flush.
   input wire logic in_valid, // Write request.
   output logic in_ready, // Room for a word.
   input wire logic [W-1:0] in_data, // Word to store.
   output logic out_valid, // A word is waiting.
   input wire logic out_ready, // Drain side takes the word.
   output logic [W-1:0] out_data, // Oldest word.
   output logic [$clog2(D+1)-1:0] count // Words held.
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   // Whole state of the FIFO.
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } a4sf_fst_t;
   a4sf_fst_t q; // Registered state.
   a4sf_fst_t n; // Next state.
   logic pu; // Accepted write.
   logic po; // Accepted read.

   // Refuse depths the pointer wrap cannot serve.
   if (D < 2 || W < 1) begin : g_chk
      $error("a4sf_fifo: depth below two or width below one");
   end

   assign in_ready = (q.cnt != CW'(D));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign count = q.cnt;
   assign pu = in_valid && in_ready;
   assign po = out_valid && out_ready;

   // Pointer and count update; a flush wins over traffic.
   always_comb begin
      n = q;
      if (clr) begin
         n.wp = '0;
         n.rp = '0;
         n.cnt = '0;
      end else begin
         if (pu) begin
            n.mem[q.wp] = in_data;
            n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
         end
         if (po) begin
            n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
         end
         n.cnt = q.cnt + CW'(pu) - CW'(po);
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rstn)
      (in_valid && !in_ready && !clr && !po) |=> (count == $past(count)))
      else $error("full FIFO accepted a word");
endmodule

module a4sf_top #(
   parameter int DEPTH = `A4SF_FIFO_DEPTH
) (
   input wire logic clk, // 50 MHz system clock.
   input wire logic rstn, // Asynchronous reset, active low.
   input wire logic fifo_flag_clear_pulse, // High pulse flushes all.
   input wire logic arinc_clk_in, // Line timing clock, asynchronous.
   input wire logic spi_cs_n, // SPI select, active low.
   input wire logic spi_sclk, // SPI clock, mode 0.
   input wire logic spi_mosi, // SPI data in.
   output logic spi_miso, // SPI data out.
   input wire a4sf_pkg::a4sf_line_t rx_a_line, // Receiver A line.
   input wire a4sf_pkg::a4sf_line_t rx_b_line, // Receiver B line.
   output a4sf_pkg::a4sf_line_t tx_line, // Transmit line drive.
   output logic rx_a_box_one_full, // Receiver A mailbox 1 unread.
   output logic rx_a_box_two_full, // Receiver A mailbox 2 unread.
   output logic rx_a_box_three_full, // Receiver A mailbox 3 unread.
   output logic rx_b_box_one_full, // Receiver B mailbox 1 unread.
   output logic rx_b_box_two_full, // Receiver B mailbox 2 unread.
   output logic rx_b_box_three_full, // Receiver B mailbox 3 unread.
   output logic rx_a_irq_out, // Receiver A interrupt.
   output logic rx_b_irq_out, // Receiver B interrupt.
   output logic rx_a_flag_out, // Receiver A flag.
   output logic rx_b_flag_out, // Receiver B flag.
   output logic tx_queue_empty_out, // Transmit FIFO empty.
   output logic tx_queue_full_out // Transmit FIFO full.
);
   import a4sf_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);

   // Whole state of the core.
   typedef struct packed {
      logic [8:0] s1;
      logic [8:0] s2;
      logic [8:0] s3;
      logic [7:0] sh_in;
      logic [2:0] bitc;
      logic [2:0] byte_n;
      logic [7:0] op;
      logic [7:0] arg0;
      logic [31:0] txw;
      logic [31:0] out_sh;
      logic miso;
      logic [2:0] rate;
      logic [7:0] assign_sel;
      logic [1:0][255:0] lbl_en;
      logic [1:0][2:0][7:0] mb_lbl;
      logic [1:0][2:0] mb_en;
      logic [1:0][2:0][31:0] mb_data;
      logic [1:0][2:0] mb_full;
      logic [1:0][31:0] rx_sh;
      logic [1:0][5:0] rx_n;
      logic [1:0][3:0] rx_gap;
      logic [1:0][6:0] rx_div;
      a4sf_tx_st_t tx_st;
      logic [31:0] tx_word;
      logic [5:0] tx_n;
      logic [6:0] tx_div;
      logic tx_ph;
      a4sf_line_t line;
      logic txe;
      logic txf;
      logic [1:0] flag;
      logic [1:0] irq;
   } a4sf_st_t;
   a4sf_st_t q; // Registered state.
   a4sf_st_t n; // Next state.
   logic [8:0] raw; // Asynchronous inputs before the synchroniser.
   logic clr_req; // Synchronised clear pulse level.
   logic aclk_edge; // Rising edge of the timing clock.
   logic sclk_rise; // SPI sampling edge.
   logic sclk_fall; // SPI shifting edge.
   logic [7:0] byte_v; // Byte completed on this sampling edge.
   logic txf_push, txf_ready, txf_valid, txf_pop; // Transmit FIFO.
   logic [31:0] txf_out; // Transmit FIFO head.
   logic [CW-1:0] txf_cnt; // Transmit FIFO fill.
   logic [1:0] rxf_push, rxf_ready, rxf_valid, rxf_pop; // Receive FIFOs.
   logic [1:0][31:0] rxf_data; // Receive FIFO input words.
   logic [1:0][31:0] rxf_out; // Receive FIFO heads.
   logic [1:0][CW-1:0] rxf_cnt; // Receive FIFO fills.
   logic [1:0] mb_took; // Word went to a mailbox.
   logic [1:0] rx_tick; // Half-bit ticks per receiver.
   logic [1:0] rx_half; // Receive FIFOs at least half full.
   logic tx_tick; // Half-bit tick of the transmitter.

   // Refuse settings the SPI sampler or the dividers cannot serve.
   if (`A4SF_SPI_CYC < 4 || `A4SF_HALF_LO > 128 || DEPTH < 2) begin : g_chk
      $error("a4sf_top: clock ratio, divider or depth out of range");
   end

   // Half-bit divider limit for the selected rate.
   function automatic logic [6:0] half_lim(input logic slow);
      half_lim = slow ? 7'(`A4SF_HALF_LO - 1) : 7'(`A4SF_HALF_HI - 1);
   endfunction

   // Evaluate one selectable pin condition.
   function automatic logic cond_hit(input logic [1:0] sel,
         input logic empty, input logic half, input logic full,
         input logic mbox);
      case (a4sf_cond_t'(sel))
         A4SF_C_NONEMPTY: cond_hit = !empty;
         A4SF_C_HALF: cond_hit = half;
         A4SF_C_FULL: cond_hit = full;
         A4SF_C_MBOX: cond_hit = mbox;
         default: cond_hit = 1'b0;
      endcase
   endfunction

   assign raw = {fifo_flag_clear_pulse, arinc_clk_in, spi_cs_n, spi_sclk,
      spi_mosi, rx_a_line.hi, rx_a_line.lo, rx_b_line.hi, rx_b_line.lo};
   assign clr_req = q.s2[`A4SF_I_CLR];
   assign aclk_edge = q.s2[`A4SF_I_ACLK] && !q.s3[`A4SF_I_ACLK];
   assign sclk_rise = q.s2[`A4SF_I_SCLK] && !q.s3[`A4SF_I_SCLK];
   assign sclk_fall = !q.s2[`A4SF_I_SCLK] && q.s3[`A4SF_I_SCLK];
   assign byte_v = {q.sh_in[6:0], q.s2[`A4SF_I_MOSI]};
   assign tx_tick = aclk_edge && (q.tx_div == half_lim(q.rate[0]));
   assign rx_tick[0] = aclk_edge && (q.rx_div[0] == half_lim(q.rate[1]));
   assign rx_tick[1] = aclk_edge && (q.rx_div[1] == half_lim(q.rate[2]));
   assign txf_pop = txf_valid && (q.tx_st == A4SF_TX_IDLE) && !clr_req;

   // Transmit FIFO; the serializer drains it only when idle.
   a4sf_fifo #(.W(32), .D(DEPTH)) u_txf (
      .clk(clk), .rstn(rstn), .clr(clr_req),
      // The last data byte joins the word in the very cycle of the push.
      .in_valid(txf_push), .in_ready(txf_ready),
      .in_data({q.txw[23:0], byte_v}),
      .out_valid(txf_valid), .out_ready(txf_pop), .out_data(txf_out),
      .count(txf_cnt));

   // One receive FIFO per receiver, drained by SPI reads.
   for (genvar c = 0; c < 2; c++) begin : g_rx
      a4sf_fifo #(.W(32), .D(DEPTH)) u_rxf (
         .clk(clk), .rstn(rstn), .clr(clr_req),
         .in_valid(rxf_push[c]), .in_ready(rxf_ready[c]),
         .in_data(rxf_data[c]), .out_valid(rxf_valid[c]),
         .out_ready(rxf_pop[c]), .out_data(rxf_out[c]),
         .count(rxf_cnt[c]));
      assign rx_half[c] = (rxf_cnt[c] >= CW'(DEPTH / 2));
   end

   // Next-state logic: SPI commands, receivers, transmitter, pins.
   always_comb begin
      n = q;
      txf_push = 1'b0;
      rxf_pop = '0;
      rxf_push = '0;
      rxf_data = q.rx_sh;
      mb_took = '0;
      n.s1 = raw;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // SPI slave: idle and silent while select is high.
      if (q.s2[`A4SF_I_CS]) begin
         n.bitc = '0;
         n.byte_n = '0;
         n.op = '0;
         n.out_sh = '0;
         n.miso = 1'b0;
      end else begin
         if (sclk_rise) begin
            n.sh_in = byte_v;
            n.bitc = q.bitc + 3'h1;
            if (q.bitc == 3'h7) begin
               if (q.byte_n != 3'h7) begin
                  n.byte_n = q.byte_n + 3'h1;
               end
               if (q.byte_n == 3'h0) begin
                  // Opcode byte; reads load the answer now.
                  n.op = byte_v;
                  case (byte_v)
                     `A4SF_CMD_RXR_A, `A4SF_CMD_RXR_B: begin
                        n.out_sh = rxf_valid[byte_v[0]] ?
                           rxf_out[byte_v[0]] : 32'h0;
                        rxf_pop[byte_v[0]] = rxf_valid[byte_v[0]];
                     end
                     `A4SF_CMD_STAT: begin
                        n.out_sh = {18'h0, q.mb_full, !rxf_ready[1],
                           rx_half[1], !rxf_valid[1], !rxf_ready[0],
                           rx_half[0], !rxf_valid[0], !txf_ready,
                           !txf_valid};
                     end
                     default: begin
                        // Mailbox read: snapshot, then mark as read.
                        if (byte_v[7:4] == `A4SF_CMD_MBR_HI &&
                              byte_v[1:0] != 2'h3) begin
                           n.out_sh = q.mb_data[byte_v[2]][byte_v[1:0]];
                           n.mb_full[byte_v[2]][byte_v[1:0]] = 1'b0;
                        end
                     end
                  endcase
               end else begin
                  // Argument bytes of write commands.
                  if (q.byte_n == 3'h1) begin
                     n.arg0 = byte_v;
                  end
                  n.txw = {q.txw[23:0], byte_v};
                  case (q.op)
                     `A4SF_CMD_CFG: begin
                        if (q.byte_n == 3'h1) begin
                           n.rate = byte_v[2:0];
                        end
                     end
                     `A4SF_CMD_ASSIGN: begin
                        if (q.byte_n == 3'h1) begin
                           n.assign_sel = byte_v;
                        end
                     end
                     `A4SF_CMD_TXW: begin
                        txf_push = (q.byte_n == 3'h4);
                     end
                     `A4SF_CMD_LBL_A, `A4SF_CMD_LBL_B: begin
                        if (q.byte_n == 3'h2) begin
                           n.lbl_en[q.op[0]][q.arg0] = byte_v[0];
                        end
                     end
                     `A4SF_CMD_MBL_A, `A4SF_CMD_MBL_B: begin
                        if (q.byte_n == 3'h2 && q.arg0[1:0] != 2'h3) begin
                           n.mb_lbl[q.op[0]][q.arg0[1:0]] = byte_v;
                           n.mb_en[q.op[0]][q.arg0[1:0]] = !q.arg0[7];
                        end
                     end
                     default: begin
                        n.arg0 = n.arg0;
                     end
                  endcase
               end
            end
         end
         if (sclk_fall) begin
            n.miso = q.out_sh[31];
            n.out_sh = {q.out_sh[30:0], 1'b0};
         end
      end
      // Receivers: RZ decode, gap timeout, mailbox then label filter.
      for (int c = 0; c < 2; c++) begin
         if (aclk_edge) begin
            n.rx_div[c] = rx_tick[c] ? 7'h0 : q.rx_div[c] + 7'h1;
         end
         if (q.rx_n[c] == 6'd32) begin
            n.rx_n[c] = '0;
            for (int k = 0; k < 3; k++) begin
               if (!mb_took[c] && q.mb_en[c][k] &&
                     q.mb_lbl[c][k] == q.rx_sh[c][7:0]) begin
                  mb_took[c] = 1'b1;
                  n.mb_data[c][k] = q.rx_sh[c];
                  n.mb_full[c][k] = 1'b1;
               end
            end
            rxf_push[c] = !mb_took[c] && q.lbl_en[c][q.rx_sh[c][7:0]];
         end else if ((q.s2[3-2*c] && !q.s3[3-2*c]) ||
               (q.s2[2-2*c] && !q.s3[2-2*c])) begin
            n.rx_sh[c] = {q.s2[3-2*c], q.rx_sh[c][31:1]};
            n.rx_n[c] = q.rx_n[c] + 6'h1;
            n.rx_gap[c] = '0;
         end else if (rx_tick[c] && q.rx_gap[c] != `A4SF_RX_GAP_HALF) begin
            n.rx_gap[c] = q.rx_gap[c] + 4'h1;
            if (q.rx_gap[c] == `A4SF_RX_GAP_HALF - 4'h1) begin
               n.rx_n[c] = '0;
            end
         end
      end
      // Transmitter: RZ bit cells on half-bit ticks, then a null gap.
      if (aclk_edge) begin
         n.tx_div = tx_tick ? 7'h0 : q.tx_div + 7'h1;
      end
      case (q.tx_st)
         A4SF_TX_IDLE: begin
            n.line = '0;
            if (txf_pop) begin
               n.tx_word = txf_out;
               n.line = {txf_out[0], !txf_out[0]};
               n.tx_n = '0;
               n.tx_ph = 1'b0;
               n.tx_div = '0;
               n.tx_st = A4SF_TX_BIT;
            end
         end
         A4SF_TX_BIT: begin
            if (tx_tick && !q.tx_ph) begin
               n.line = '0;
               n.tx_ph = 1'b1;
            end else if (tx_tick) begin
               n.tx_ph = 1'b0;
               n.tx_word = {1'b0, q.tx_word[31:1]};
               n.tx_n = q.tx_n + 6'h1;
               if (q.tx_n == 6'd31) begin
                  n.tx_n = '0;
                  n.tx_st = A4SF_TX_GAP;
               end else begin
                  n.line = {q.tx_word[1], !q.tx_word[1]};
               end
            end
         end
         A4SF_TX_GAP: begin
            n.line = '0;
            if (tx_tick) begin
               n.tx_n = q.tx_n + 6'h1;
               if (q.tx_n == `A4SF_TX_GAP_HALF - 6'h1) begin
                  n.tx_st = A4SF_TX_IDLE;
               end
            end
         end
         default: begin
            n.tx_st = A4SF_TX_IDLE;
         end
      endcase
      // Pin images of FIFO and mailbox state.
      n.txe = !txf_valid;
      n.txf = !txf_ready;
      for (int c = 0; c < 2; c++) begin
         n.flag[c] = cond_hit(q.assign_sel[4*c +: 2], !rxf_valid[c],
            rx_half[c], !rxf_ready[c], |q.mb_full[c]);
         n.irq[c] = cond_hit(q.assign_sel[4*c+2 +: 2], !rxf_valid[c],
            rx_half[c], !rxf_ready[c], |q.mb_full[c]);
      end
      // Clear pulse flushes data and flags, settings are kept.
      if (clr_req) begin
         n.mb_full = '0;
         n.rx_n = '0;
         n.tx_st = A4SF_TX_IDLE;
         n.line = '0;
         n.txe = 1'b1;
         n.txf = 1'b0;
         n.flag = '0;
         n.irq = '0;
      end
   end

   // State register; empty pin and idle select come out of reset high.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.s1 <= `A4SF_SYNC_RST;
         q.s2 <= `A4SF_SYNC_RST;
         q.s3 <= `A4SF_SYNC_RST;
         q.txe <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign spi_miso = q.miso;
   assign tx_line = q.line;
   assign {rx_a_box_three_full, rx_a_box_two_full, rx_a_box_one_full} =
      q.mb_full[0];
   assign {rx_b_box_three_full, rx_b_box_two_full, rx_b_box_one_full} =
      q.mb_full[1];
   assign {rx_b_flag_out, rx_a_flag_out} = q.flag;
   assign {rx_b_irq_out, rx_a_irq_out} = q.irq;
   assign tx_queue_empty_out = q.txe;
   assign tx_queue_full_out = q.txf;

   a_clr_empties: assert property (@(posedge clk) disable iff (!rstn)
      clr_req |=> (tx_queue_empty_out && !tx_queue_full_out && !txf_valid))
      else $error("clear pulse left transmit FIFO state");
   a_clr_pins_low: assert property (@(posedge clk) disable iff (!rstn)
      clr_req |=> (q.mb_full == '0 && q.flag == '0 && q.irq == '0))
      else $error("clear pulse left pins high");
   a_tx_empty_pin: assert property (@(posedge clk) disable iff (!rstn)
      !clr_req |=> (tx_queue_empty_out == !$past(txf_valid)))
      else $error("empty pin disagrees with FIFO");
   a_tx_full_pin: assert property (@(posedge clk) disable iff (!rstn)
      (!clr_req && txf_cnt == CW'(DEPTH)) |=> tx_queue_full_out)
      else $error("full pin low with full FIFO");
   a_spi_cs_gate: assert property (@(posedge clk) disable iff (!rstn)
      q.s2[`A4SF_I_CS] |=> (!txf_push && !spi_miso))
      else $error("SPI active while deselected");
   a_label_gate: assert property (@(posedge clk) disable iff (!rstn)
      rxf_push[0] |-> q.lbl_en[0][rxf_data[0][7:0]])
      else $error("disabled label stored");
   a_box_pin: assert property (@(posedge clk) disable iff (!rstn)
      (q.rx_n[0] == 6'd32 && mb_took[0] && !clr_req) |=>
      (rx_a_box_one_full || rx_a_box_two_full || rx_a_box_three_full))
      else $error("mailbox pin low after delivery");
   a_tx_idle_null: assert property (@(posedge clk) disable iff (!rstn)
      (q.tx_st == A4SF_TX_IDLE) |-> (tx_line == '0))
      else $error("line driven while idle");
endmodule

// ===== bench/a4sf_host_model.sv
// Partner model: SPI host, line sources and transmit line monitor.
`timescale 1ns/1ps
module a4sf_host_model (
   input wire logic clk, // System clock.
   output logic arinc_clk_in, // Free-running line timing clock.
   output logic spi_cs_n, // SPI select, active low.
   output logic spi_sclk, // SPI clock.
   output logic spi_mosi, // Host data out.
   input wire logic spi_miso, // Host data in.
   output a4sf_pkg::a4sf_line_t rx_a_line, // Line into receiver A.
   output a4sf_pkg::a4sf_line_t rx_b_line, // Line into receiver B.
   input wire a4sf_pkg::a4sf_line_t tx_line // Line from transmitter.
);
   import a4sf_pkg::*;
   a4sf_line_t lines [2] = '{2'b00, 2'b00}; // Driven line pairs.
   logic [31:0] tx_word = 32'h0; // Word seen on the line.
   int tx_cnt = 0; // Bits seen on the line.
   a4sf_line_t tx_prev = 2'b00; // Line level one clock ago.
   assign rx_a_line = lines[0];
   assign rx_b_line = lines[1];
   // Idle host levels; the timing clock runs free at 1 MHz.
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
      arinc_clk_in = 1'b0;
      forever #500 arinc_clk_in = ~arinc_clk_in;
   end
   // A bit starts where the line leaves null; LSB arrives first.
   always @(posedge clk) begin
      if (tx_prev == 2'b00 && tx_line != 2'b00) begin
         tx_word <= {tx_line.hi, tx_word[31:1]};
         tx_cnt <= tx_cnt + 1;
      end
      tx_prev <= tx_line;
   end
   // One command per select period, mode 0, each level 4 clocks.
   task automatic spi_cmd(input logic [7:0] op, input int n,
         input logic [31:0] data, output logic [31:0] rd);
      logic [39:0] sh;
      sh = {op, data << (32 - n)};
      rd = 32'h0;
      @(negedge clk);
      spi_cs_n = 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         spi_mosi = sh[39 - i];
         repeat (4) @(negedge clk);
         spi_sclk = 1'b1;
         repeat (4) @(negedge clk);
         rd = {rd[30:0], spi_miso};
         spi_sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      repeat (8) @(negedge clk);
   endtask
   // Return-to-zero word, LSB first, 2 us pulse and 2 us null per bit.
   task automatic line_send(input int rx, input logic [31:0] w);
      for (int i = 0; i < 32; i++) begin
         lines[rx] = w[i] ? 2'b10 : 2'b01;
         repeat (100) @(negedge clk);
         lines[rx] = 2'b00;
         repeat (100) @(negedge clk);
      end
      repeat (20) @(negedge clk);
   endtask
endmodule

// ===== bench/a4sf_top_tb_top.sv
// Self-checking bench for the ARINC 429 SPI front end.
`timescale 1ns/1ps
`include "a4sf_defs.svh"
module a4sf_top_tb_top;
   import a4sf_pkg::*;
   logic clk, rstn, clr, aclk, cs_n, sclk, mosi, miso, e_o, f_o;
   a4sf_line_t la, lb, tl; // Line pairs.
   logic [5:0] box; // Mailbox pins, A then B.
   logic [1:0] irq, flg; // Interrupt and flag pins.
   logic [31:0] w, rd; // Word sent and word read back.
   logic [7:0] lbl; // Label under test.
   int seed, n_errors = 0, total_checks = 0;
   a4sf_host_model host (.clk(clk), .arinc_clk_in(aclk), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .rx_a_line(la),
      .rx_b_line(lb), .tx_line(tl));
   a4sf_top #(.DEPTH(32)) uut (.clk(clk), .rstn(rstn),
      .fifo_flag_clear_pulse(clr), .arinc_clk_in(aclk), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .rx_a_line(la),
      .rx_b_line(lb), .tx_line(tl), .rx_a_box_one_full(box[0]),
      .rx_a_box_two_full(box[1]), .rx_a_box_three_full(box[2]),
      .rx_b_box_one_full(box[3]), .rx_b_box_two_full(box[4]),
      .rx_b_box_three_full(box[5]), .rx_a_irq_out(irq[0]),
      .rx_b_irq_out(irq[1]), .rx_a_flag_out(flg[0]),
      .rx_b_flag_out(flg[1]), .tx_queue_empty_out(e_o),
      .tx_queue_full_out(f_o));
   // 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Status word: mailboxes, B and A {full,half,empty}, tx full, empty.
   function automatic logic [31:0] exp_stat(input logic [5:0] mb,
         input logic [2:0] b, input logic [2:0] a, input logic [1:0] t);
      return {18'h0, mb, b, a, t};
   endfunction
   // Random word that carries the given label in its low byte.
   function automatic logic [31:0] with_label(input logic [7:0] l);
      return {24'($random(seed)), l};
   endfunction
   task automatic chk_bit(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog sized well above the expected run of about 65000 clocks.
   initial begin
      repeat (95000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      seed = 70;
      rstn = 1'b0;
      clr = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      chk_bit("empty", 1'b1, e_o);
      chk_word("pins", 32'h0, {f_o, box, irq, flg});
      $display("Test reset done");
      host.spi_cmd(`A4SF_CMD_CFG, 8, 32'h00, rd);
      host.spi_cmd(`A4SF_CMD_ASSIGN, 8, 32'h0C, rd);
      w = $random(seed);
      host.spi_cmd(`A4SF_CMD_TXW, 32, w, rd);
      for (int i = 0; i < 40000 && host.tx_cnt < 32; i++) @(negedge clk);
      chk_word("line word", w, host.tx_word);
      // Let the last bit and the null gap end so the serializer is idle.
      repeat (3000) @(negedge clk);
      $display("Test line out done");
      // The first write goes to the serializer, so 33 fill the queue.
      host.spi_cmd(`A4SF_CMD_CFG, 8, 32'h01, rd);
      for (int i = 0; i < 33; i++) begin
         chk_bit("full early", 1'b0, f_o);
         host.spi_cmd(`A4SF_CMD_TXW, 32, $random(seed), rd);
      end
      chk_bit("full", 1'b1, f_o);
      chk_bit("empty busy", 1'b0, e_o);
      host.spi_cmd(`A4SF_CMD_STAT, 32, 32'h0, rd);
      chk_word("status", exp_stat(6'h0, 3'h1, 3'h1, 2'h2), rd);
      clr = 1'b1;
      repeat (4) @(negedge clk);
      clr = 1'b0;
      repeat (4) @(negedge clk);
      chk_bit("empty clear", 1'b1, e_o);
      chk_bit("full clear", 1'b0, f_o);
      $display("Test fill and clear done");
      host.spi_cmd(`A4SF_CMD_CFG, 8, 32'h00, rd);
      for (int rx = 0; rx < 2; rx++) begin
         lbl = 8'($random(seed));
         w = with_label(lbl);
         host.spi_cmd(8'(`A4SF_CMD_LBL_A + rx), 16, {lbl, 8'h01}, rd);
         host.spi_cmd(8'(`A4SF_CMD_LBL_A + rx), 16, {lbl ^ 8'h01, 8'h00}, rd);
         host.line_send(rx, w);
         host.line_send(rx, w ^ 32'h1);
         chk_bit("flag", 1'b1, flg[rx]);
         host.spi_cmd(8'(`A4SF_CMD_RXR_A + rx), 32, 32'h0, rd);
         chk_word("rx word", w, rd);
         host.spi_cmd(8'(`A4SF_CMD_RXR_A + rx), 32, 32'h0, rd);
         chk_word("rx dropped", 32'h0, rd);
      end
      $display("Test receive done");
      lbl = 8'($random(seed));
      w = with_label(lbl);
      host.spi_cmd(`A4SF_CMD_MBL_A, 16, {8'h00, lbl}, rd);
      host.line_send(0, w);
      chk_bit("box pin", 1'b1, box[0]);
      chk_bit("irq", 1'b1, irq[0]);
      host.spi_cmd({`A4SF_CMD_MBR_HI, 4'h0}, 32, 32'h0, rd);
      chk_word("box word", w, rd);
      chk_bit("box read", 1'b0, box[0]);
      $display("Test mailbox done");
      print_verdict();
   end
endmodule
